// ==== hw/amp_control_register_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module amp_control_register_bank
   import amp_ctrl_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2a,
   // Arbitrary identification value
   parameter logic [7:0] ID_CODE  = 8'h5a
)(
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output var  logic sda_out,
   output var  logic sda_oe,
   output var  amp_ctrl_t ctrl
);

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_PTR,
      ST_PTR_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK
   } i2c_state_t;

   function automatic logic [7:0] write_mask(input int idx);
      case (idx)
         1:       write_mask = WMASK_POWER;
         2:       write_mask = WMASK_DIGITAL;
         3:       write_mask = WMASK_VOL_CFG;
         4, 5:    write_mask = WMASK_VOLUME;
         default: write_mask = WMASK_IDENT;
      endcase
   endfunction

   function automatic logic [7:0] reset_value(input int idx);
      case (idx)
         1:       reset_value = RST_POWER;
         2:       reset_value = RST_DIGITAL;
         3:       reset_value = RST_VOL_CFG;
         4, 5:    reset_value = RST_VOLUME;
         default: reset_value = 8'h00;
      endcase
   endfunction

   i2c_ev_t    ev;
   i2c_state_t state_q;
   i2c_state_t state_d;
   logic [7:0] sr_q;
   logic [7:0] sr_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [7:0] ptr_q;
   logic [7:0] ptr_d;
   logic       oe_q;
   logic       oe_d;
   logic       mack_q;
   logic       mack_d;
   logic       sda_out_q;
   logic [7:0] regs_q [1:REG_LAST];
   logic [7:0] rd_table [0:7];
   amp_ctrl_t  ctrl_d;
   amp_ctrl_t  ctrl_q;

   i2c_line_events u_events (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .ev      (ev)
   );

   wire logic       byte_done = (cnt_q == BITS_PER_BYTE);
   wire logic [7:0] sr_shift  = {sr_q[6:0], ev.sda};
   wire logic       addr_hit  = (sr_q[7:1] == DEV_ADDR);
   wire logic       ptr_inmap = (ptr_q <= OFS_RGHT_VOL);
   wire logic [7:0] rd_val    = ptr_inmap ? rd_table[ptr_q[2:0]] : 8'h00;
   wire logic       wr_stb    = (state_q == ST_WDATA) & ev.fall & byte_done;
   wire logic       rd_load   = ev.fall & (((state_q == ST_ADDR_ACK) &
                                sr_q[0]) | ((state_q == ST_RDATA_ACK) &
                                mack_q));

   // Read view: identification is a constant, never a stored byte
   assign rd_table[0] = ID_CODE;
   genvar gi;
   generate
      for (gi = 1; gi <= REG_LAST; gi++) begin : g_regs
         wire logic       hit = wr_stb & (ptr_q == 8'(gi));
         wire logic [7:0] msk = write_mask(gi);
         wire logic [7:0] nxt = (regs_q[gi] & ~msk) | (sr_q & msk);
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               regs_q[gi] <= reset_value(gi);
            end else if (hit) begin
               regs_q[gi] <= nxt;
            end
         end
         assign rd_table[gi] = regs_q[gi];
      end
      for (gi = REG_LAST + 1; gi < 8; gi++) begin : g_unmapped
         assign rd_table[gi] = 8'h00;
      end
   endgenerate

   // Serial control port sequencing
   always_comb begin
      state_d = state_q;
      sr_d    = sr_q;
      cnt_d   = cnt_q;
      ptr_d   = ptr_q;
      oe_d    = oe_q;
      mack_d  = mack_q;
      if (ev.start) begin
         state_d = ST_ADDR;
         cnt_d   = 4'h0;
         oe_d    = 1'b0;
      end else if (ev.stop) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else if (rd_load) begin
         sr_d    = {rd_val[6:0], 1'b0};
         oe_d    = ~rd_val[7];
         cnt_d   = 4'h1;
         state_d = ST_RDATA;
      end else begin
         case (state_q)
            ST_ADDR, ST_PTR, ST_WDATA: begin
               if (ev.rise) begin
                  sr_d  = sr_shift;
                  cnt_d = cnt_q + 4'h1;
               end else if (ev.fall && byte_done) begin
                  oe_d = 1'b1;
                  case (state_q)
                     ST_ADDR: begin
                        oe_d    = addr_hit;
                        state_d = addr_hit ? ST_ADDR_ACK : ST_IDLE;
                     end
                     ST_PTR: begin
                        ptr_d   = sr_q;
                        state_d = ST_PTR_ACK;
                     end
                     default: begin
                        ptr_d   = ptr_q + 8'h01;
                        state_d = ST_WDATA_ACK;
                     end
                  endcase
               end
            end
            ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
               if (ev.fall) begin
                  oe_d    = 1'b0;
                  cnt_d   = 4'h0;
                  state_d = (state_q == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (ev.fall) begin
                  if (byte_done) begin
                     oe_d    = 1'b0;
                     ptr_d   = ptr_q + 8'h01;
                     state_d = ST_RDATA_ACK;
                  end else begin
                     oe_d  = ~sr_q[7];
                     sr_d  = {sr_q[6:0], 1'b0};
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
            ST_RDATA_ACK: begin
               if (ev.rise) begin
                  mack_d = ~ev.sda;
               end else if (ev.fall) begin
                  state_d = ST_IDLE;
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q   <= ST_IDLE;
         sr_q      <= 8'h00;
         cnt_q     <= 4'h0;
         ptr_q     <= 8'h00;
         oe_q      <= 1'b0;
         mack_q    <= 1'b0;
         sda_out_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         sr_q      <= sr_d;
         cnt_q     <= cnt_d;
         ptr_q     <= ptr_d;
         oe_q      <= oe_d;
         mack_q    <= mack_d;
         sda_out_q <= 1'b0;
      end
   end

   // Control outputs decoded from the stored bytes
   wire logic [7:0] pwr = regs_q[1];
   wire logic [7:0] dig = regs_q[2];
   wire logic [7:0] vcf = regs_q[3];
   wire logic [7:0] vl  = regs_q[4];
   wire logic [7:0] vr  = regs_q[5];
   wire logic [1:0] bst = dig[POS_BOOST +: 2];
   wire logic       vl_low = (vl < VOL_MUTE_FLOOR);
   wire logic       vr_low = (vr < VOL_MUTE_FLOOR);

   assign ctrl_d.clip_hi        = pwr[POS_CLIP_HI +: W_CLIP_HI];
   assign ctrl_d.power_stage_en = pwr[POS_SPK_ON] & ~pwr[POS_SLEEP];
   assign ctrl_d.low_power      = ~pwr[POS_SPK_ON];
   assign ctrl_d.hpf_bypass     = dig[POS_HPF_BYP];
   assign ctrl_d.boost_db       = 5'(bst) * BOOST_STEP_DB;
   assign ctrl_d.double_speed   = dig[POS_SPEED];
   assign ctrl_d.input_format   = dig[POS_FORMAT +: 3];
   assign ctrl_d.format_valid   = dig[POS_FORMAT +: 3] <= FMT_LAST_VALID;
   assign ctrl_d.fade_en        = vcf[POS_FADE];
   assign ctrl_d.mute_r         = vcf[POS_MUTE_R] | vr_low;
   assign ctrl_d.mute_l         = vcf[POS_MUTE_L] | vl_low;
   assign ctrl_d.vol_l          = vl;
   assign ctrl_d.vol_r          = vr;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   assign ctrl    = ctrl_q;
   assign sda_oe  = oe_q;
   assign sda_out = sda_out_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_data_byte;
      (state_q == ST_WDATA) && ev.fall && byte_done;
   endsequence

   sequence s_master_nack;
      (state_q == ST_RDATA_ACK) && ev.rise && ev.sda && !ev.start &&
         !ev.stop;
   endsequence

   sequence s_any_edge;
      ev.fall && !ev.start && !ev.stop;
   endsequence

   // Checks the byte actually loaded for shifting out, not the table
   a_ident_fixed: assert property (
      rd_load && ptr_q == OFS_IDENT && !ev.start && !ev.stop
      |=> sr_q == {ID_CODE[6:0], 1'b0} && oe_q == !ID_CODE[7])
      else $error("identification byte changed");

   // The decoded outputs lag the stored bytes by one edge after reset
   a_clip_upper: assert property (
      $past(nrst) |-> ctrl_q.clip_hi == $past(regs_q[1][7:2]))
      else $error("clip threshold top bits wrong");

   a_power_states: assert property (
      $past(nrst) |->
      ctrl_q.power_stage_en == $past(regs_q[1][0] && !regs_q[1][1]) &&
      ctrl_q.low_power == $past(!regs_q[1][0]))
      else $error("power stage state wrong");

   a_reserved_zero: assert property (
      regs_q[2][6] == 1'b0 && regs_q[3][6:2] == 5'h00)
      else $error("reserved bits not zero");

   a_boost_gain: assert property (
      $past(regs_q[2][5:4]) == 2'h3 |-> ctrl_q.boost_db == 5'd18)
      else $error("boost gain wrong");

   a_digital_fields: assert property (
      $past(nrst) |->
      {ctrl_q.hpf_bypass, ctrl_q.double_speed, ctrl_q.input_format} ==
      $past({regs_q[2][7], regs_q[2][3], regs_q[2][2:0]}))
      else $error("digital control fields wrong");

   a_mute_floor: assert property (
      $past(regs_q[4]) < 8'h07 |-> ctrl_q.mute_l && ctrl_q.vol_l < 8'h07)
      else $error("low volume code not muting");

   a_mute_bits: assert property (
      $past(regs_q[3][1:0]) == 2'h3 && $past(regs_q[3][7])
      |-> ctrl_q.mute_r && ctrl_q.mute_l && ctrl_q.fade_en)
      else $error("mute or fade not applied");

   a_write_ack: assert property (
      s_data_byte and (!ev.start && !ev.stop)
      |=> oe_q && state_q == ST_WDATA_ACK && ptr_q == $past(ptr_q) + 8'h01)
      else $error("data byte not acknowledged");

   a_write_lands: assert property (
      wr_stb && ptr_q == OFS_VOL_CFG
      |=> regs_q[3] == ($past(sr_q) & WMASK_VOL_CFG))
      else $error("masked write wrong");

   a_read_nack_end: assert property (
      s_master_nack ##[1:12] s_any_edge |=> state_q == ST_IDLE && !oe_q)
      else $error("read not ended after nack");

endmodule
`default_nettype wire

// ==== hw/amp_ctrl_pkg.sv ====
package amp_ctrl_pkg;

   // Register offsets
   localparam logic [7:0] OFS_IDENT    = 8'h00;
   localparam logic [7:0] OFS_POWER    = 8'h01;
   localparam logic [7:0] OFS_DIGITAL  = 8'h02;
   localparam logic [7:0] OFS_VOL_CFG  = 8'h03;
   localparam logic [7:0] OFS_LEFT_VOL = 8'h04;
   localparam logic [7:0] OFS_RGHT_VOL = 8'h05;
   localparam int         REG_LAST     = 5;

   // Values after reset
   localparam logic [7:0] RST_POWER    = 8'hfd;
   localparam logic [7:0] RST_DIGITAL  = 8'h14;
   localparam logic [7:0] RST_VOL_CFG  = 8'h80;
   localparam logic [7:0] RST_VOLUME   = 8'hcf;

   // Writable bits; read-only positions ignore writes and reserved positions stay zero
   localparam logic [7:0] WMASK_IDENT   = 8'h00;
   localparam logic [7:0] WMASK_POWER   = 8'hff;
   localparam logic [7:0] WMASK_DIGITAL = 8'hbf;
   localparam logic [7:0] WMASK_VOL_CFG = 8'h83;
   localparam logic [7:0] WMASK_VOLUME  = 8'hff;

   // Field positions
   localparam int POS_CLIP_HI  = 2;
   localparam int W_CLIP_HI    = 6;
   localparam int POS_SLEEP    = 1;
   localparam int POS_SPK_ON   = 0;
   localparam int POS_HPF_BYP  = 7;
   localparam int POS_RSVD_DIG = 6;
   localparam int POS_BOOST    = 4;
   localparam int POS_SPEED    = 3;
   localparam int POS_FORMAT   = 0;
   localparam int POS_FADE     = 7;
   localparam int POS_MUTE_R   = 1;
   localparam int POS_MUTE_L   = 0;

   localparam logic [7:0] VOL_MUTE_FLOOR = 8'h07;
   localparam logic [2:0] FMT_LAST_VALID = 3'h5;
   localparam logic [4:0] BOOST_STEP_DB  = 5'h06;
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

   typedef enum logic [2:0] {
      FMT_RJ24 = 3'h0,
      FMT_RJ20 = 3'h1,
      FMT_RJ18 = 3'h2,
      FMT_RJ16 = 3'h3,
      FMT_I2S  = 3'h4,
      FMT_LJ   = 3'h5
   } audio_fmt_t;

   typedef struct packed {
      logic [5:0] clip_hi;
      logic       power_stage_en;
      logic       low_power;
      logic       hpf_bypass;
      logic [4:0] boost_db;
      logic       double_speed;
      logic [2:0] input_format;
      logic       format_valid;
      logic       fade_en;
      logic       mute_r;
      logic       mute_l;
      logic [7:0] vol_l;
      logic [7:0] vol_r;
   } amp_ctrl_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
      logic sda;
   } i2c_ev_t;

endpackage

// ==== hw/i2c_line_events.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_line_events
   import amp_ctrl_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output var  i2c_ev_t ev
);
   logic    scl_q;
   logic    sda_q;
   i2c_ev_t ev_d;
   i2c_ev_t ev_q;

   // Start and stop are data edges while the clock line stays high
   assign ev_d.start = scl_q & scl_in & sda_q & ~sda_in;
   assign ev_d.stop  = scl_q & scl_in & ~sda_q & sda_in;
   assign ev_d.rise  = ~scl_q & scl_in;
   assign ev_d.fall  = scl_q & ~scl_in;
   assign ev_d.sda   = sda_in;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         ev_q  <= '0;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         ev_q  <= ev_d;
      end
   end

   assign ev = ev_q;
endmodule
`default_nettype wire

// ==== bench/i2c_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
   input  wire logic       sys_clk,
   input  wire logic       sda_line,
   output var  logic       scl,
   output var  logic       sda_drv,
   output var  logic       rsp_valid,
   output var  logic [8:0] rsp
);
   logic       nack_q;
   logic [7:0] q;
   logic       a;

   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      rsp_valid = 1'b0;
      rsp = 9'h000;
   end

   task automatic hold();
      repeat (6) @(negedge sys_clk);
   endtask

   // SDA settles while SCL is low; the line is read late in the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      hold();
      scl = 1'b1;
      hold();
      r = sda_line;
      scl = 1'b0;
      hold();
   endtask

   // b=1: start or repeated start, b=0: stop
   task automatic cond(input logic b);
      sda_drv = b;
      hold();
      scl = 1'b1;
      hold();
      sda_drv = ~b;
      hold();
      if (b) begin
         scl = 1'b0;
         hold();
      end
   endtask

   task automatic byte_io(input logic [7:0] d, input logic m);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(m, a);
   endtask

   task automatic send(input logic [7:0] d);
      byte_io(d, 1'b1);
      nack_q = nack_q | a;
   endtask

   task automatic note();
      rsp = {nack_q, q};
      rsp_valid = 1'b1;
      @(negedge sys_clk);
      rsp_valid = 1'b0;
   endtask

   task automatic head(input logic [6:0] dev, input logic [7:0] ptr);
      nack_q = 1'b0;
      cond(1'b1);
      send({dev, 1'b0});
      send(ptr);
   endtask

   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] d);
      head(dev, ptr);
      send(d);
      cond(1'b0);
      q = 8'h00;
      note();
   endtask

   task automatic read_burst(input logic [6:0] dev, input logic [7:0] ptr,
                             input int n);
      head(dev, ptr);
      cond(1'b1);
      send({dev, 1'b1});
      for (int k = 0; k < n; k++) begin
         byte_io(8'hff, k == n - 1);
         note();
      end
      cond(1'b0);
   endtask
endmodule
`default_nettype wire

// ==== bench/amp_control_register_bank_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module amp_control_register_bank_tb_top;
   import amp_ctrl_pkg::*;
   typedef struct packed {
      logic [8:0] rsp;
      amp_ctrl_t  ctrl;
   } note_t;
   localparam logic [6:0] DEV = 7'h36;
   // Arbitrary identification value
   localparam logic [7:0] ID  = 8'h3c;
   logic        sys_clk, nrst, scl, sda_drv, rsp_valid;
   logic [8:0]  rsp;
   wire logic   sda_out, sda_oe, sda_in;
   wire amp_ctrl_t ctrl;
   logic [7:0]  regs [0:255];
   logic [7:0]  vols [0:4];
   note_t       notes [$];
   note_t       nt;
   logic [31:0] seed;
   int          fails, checks, cycles;

   // Pull-up with wired-AND of both drivers
   assign sda_in = sda_drv & (~sda_oe | sda_out);

   amp_control_register_bank #(.DEV_ADDR(DEV), .ID_CODE(ID))
      u_amp_control_register_bank (
      .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl));
   i2c_host_model u_i2c_host_model (
      .sys_clk(sys_clk), .sda_line(sda_in), .scl(scl), .sda_drv(sda_drv),
      .rsp_valid(rsp_valid), .rsp(rsp));

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         8'h01, 8'h04, 8'h05: return 8'hff;
         8'h02: return 8'hbf;
         8'h03: return 8'h83;
         default: return 8'h00;
      endcase
   endfunction

   function automatic amp_ctrl_t exp_ctrl();
      amp_ctrl_t c;
      c.clip_hi        = regs[1][7:2];
      c.power_stage_en = regs[1][0] & ~regs[1][1];
      c.low_power      = ~regs[1][0];
      c.hpf_bypass     = regs[2][7];
      c.boost_db       = 5'h06 * {3'h0, regs[2][5:4]};
      c.double_speed   = regs[2][3];
      c.input_format   = regs[2][2:0];
      c.format_valid   = regs[2][2:0] <= 3'h5;
      c.fade_en        = regs[3][7];
      c.mute_r         = regs[3][1] | (regs[5] < 8'h07);
      c.mute_l         = regs[3][0] | (regs[4] < 8'h07);
      c.vol_l          = regs[4];
      c.vol_r          = regs[5];
      return c;
   endfunction

   task automatic wr(input logic [6:0] dev, input logic [7:0] a,
                     input logic [7:0] d);
      note_t n;
      if (dev == DEV) regs[a] = (regs[a] & ~wmask(a)) | (d & wmask(a));
      n.rsp = {dev != DEV, 8'h00};
      n.ctrl = exp_ctrl();
      notes.push_back(n);
      u_i2c_host_model.write_reg(dev, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input int n);
      note_t e;
      for (int k = 0; k < n; k++) begin
         e.rsp = {1'b0, regs[8'(a + k)]};
         e.ctrl = exp_ctrl();
         notes.push_back(e);
      end
      u_i2c_host_model.read_burst(DEV, a, n);
   endtask

   task automatic reset_dut();
      nrst = 1'b0;
      for (int i = 0; i < 256; i++) regs[i] = 8'h00;
      regs[0] = ID;
      regs[1] = 8'hfd;
      regs[2] = 8'h14;
      regs[3] = 8'h80;
      regs[4] = 8'hcf;
      regs[5] = 8'hcf;
      repeat (12) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk);
   endtask

   task automatic compare_rsp(input logic [8:0] e, input logic [8:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic compare_ctrl(input amp_ctrl_t e, input amp_ctrl_t g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic results();
      if (notes.size() != 0) fails++;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      if (rsp_valid === 1'b1) begin
         nt = (notes.size() != 0) ? notes.pop_front() : '1;
         compare_rsp(nt.rsp, rsp);
         compare_ctrl(nt.ctrl, ctrl);
      end
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         results();
      end
   end

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial begin
      seed = 32'h0000bfcd;
      fails = 0;
      checks = 0;
      cycles = 0;
      vols = '{8'hff, 8'hcf, 8'h07, 8'h06, 8'h00};
      reset_dut();
      rd(8'h00, 8);
      wr(DEV, 8'h00, 8'hff);
      wr(DEV, 8'h06, 8'ha5);
      for (int i = 0; i < 8; i++) begin
         wr(DEV, 8'h01, (rnd() & 8'hfc) | {6'h0, i[1:0]});
         // Reserved bits kept at zero and format codes kept legal
         wr(DEV, 8'h02, (rnd() & 8'h88) |
            {2'h0, i[1:0], 1'b0, 3'(i % 6)});
         wr(DEV, 8'h03, (rnd() & 8'h80) | {6'h0, i[1:0]});
      end
      for (int i = 0; i < 5; i++) begin
         wr(DEV, 8'h04, vols[i]);
         wr(DEV, 8'h05, vols[4 - i]);
      end
      wr(DEV ^ 7'h01, 8'h04, 8'h55);
      rd(8'hfe, 8);
      reset_dut();
      rd(8'h00, 6);
      results();
   end
endmodule
`default_nettype wire
